// File: hw/uff_pkg.sv
// Function
// - Transmitter and receiver run at the same time and independently.
// - Writing the data buffer starts a frame.
// - Transmit-done flag sets when the stop bit starts; it is the interrupt request.
// - Extra bit on, parity off: transmit extra-bit control value is sent after data.
// - Parity on: computed parity bit follows data; extra bit unavailable.
// - Frames are accepted only while receive enable is 1.
// - Byte enters the three-entry FIFO only with room and all stop bits high.
// - Byte finishing with a full FIFO is dropped and sets the overrun flag.
// - Byte with any low stop bit is not stored.
// - Storing a byte sets the receive-ready flag, which is the interrupt request.
// - With the address filter on, only frames with extra bit 1 count.
// - Reading the data buffer returns the oldest byte and frees its entry.
// - Clearing receive-ready is ignored while more than one unread byte remains.
// - Receive extra-bit status shows oldest byte's extra bit, else its stop bit.
// - Parity mismatch sets the parity error flag until software clears it.
// - Holding-empty flag shows whether a byte may be written; write only then.
// - Frame: low start, 5 to 8 data bits LSB first, option bit, stop bits.
// - Parity type codes: 00 odd, 01 even, 10 mark, 11 space.
// - Baud timer counts up from reload and reloads on overflow from all ones.
package uff_pkg;

	localparam logic [7:0]  ADDR_CTRL    = 8'h98;
	localparam logic [7:0]  ADDR_DATA    = 8'h99;
	localparam logic [7:0]  ADDR_MODE    = 8'hA9;
	localparam logic [7:0]  ADDR_RLD_LO  = 8'hAC;
	localparam logic [7:0]  ADDR_RLD_HI  = 8'hAD;

	localparam int          CTL_OVR      = 7;
	localparam int          CTL_PERR     = 6;
	localparam int          CTL_REN      = 4;
	localparam int          CTL_TBX      = 3;
	localparam int          CTL_TI       = 1;
	localparam int          CTL_RI       = 0;

	localparam logic [7:0]  MODE_RST     = 8'h0C;
	localparam logic [15:0] RLD_RST      = 16'h0000;
	localparam logic [15:0] TMR_TOP      = 16'hFFFF;
	localparam logic [1:0]  FIFO_DEPTH   = 2'h3;
	localparam logic [2:0]  SYNC_RST     = 3'h7;

	localparam logic [1:0]  PAR_ODD      = 2'h0;
	localparam logic [1:0]  PAR_EVEN     = 2'h1;
	localparam logic [1:0]  PAR_MARK     = 2'h2;
	localparam logic [1:0]  DL_5         = 2'h0;
	localparam logic [1:0]  DL_6         = 2'h1;
	localparam logic [1:0]  DL_7         = 2'h2;
	localparam logic [7:0]  MASK_5       = 8'h1F;
	localparam logic [7:0]  MASK_6       = 8'h3F;
	localparam logic [7:0]  MASK_7       = 8'h7F;
	localparam logic [7:0]  MASK_8       = 8'hFF;
	localparam logic [2:0]  LAST_IDX_5   = 3'h4;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_DATA  = 3'b010,
		ST_XBIT  = 3'b011,
		ST_STOP  = 3'b100
	} uff_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} uff_sfr_s;

	typedef struct packed {
		logic       multiproc_filter_enable;
		logic [1:0] parity_type_select;
		logic       parity_enable;
		logic [1:0] data_length_select;
		logic       extra_bit_enable;
		logic       stop2;
	} uff_mode_s;

	typedef struct packed {
		logic       xbit;
		logic [7:0] data;
	} uff_entry_s;

	typedef struct packed {
		logic                  overrun_flag;
		logic                  parity_error_flag;
		logic                  receive_enable_bit;
		logic                  tx_extra_bit;
		logic                  tx_done_flag;
		logic                  rx_ready_flag;
		uff_mode_s             mode;
		logic [15:0]           rld;
		logic [15:0]           btmr;
		logic [15:0]           rtmr;
		logic [2:0]            sync;
		logic                  rx_line;
		logic [7:0]            hold;
		logic                  hold_full;
		uff_state_e            tx_st;
		logic                  tx_half;
		logic [7:0]            tx_sh;
		logic                  tx_xb;
		logic [2:0]            tx_cnt;
		logic                  tx_line;
		uff_state_e            rx_st;
		logic                  rx_half;
		logic [7:0]            rx_sh;
		logic [2:0]            rx_cnt;
		logic                  rx_xb;
		logic                  rx_ok;
		uff_entry_s [2:0]      fifo;
		logic [1:0]            fcnt;
		logic [7:0]            rdata;
	} uff_state_s;

endpackage

// File: hw/uff_uart.sv
`timescale 1ns/1ps
`default_nettype none
module uff_uart
	import uff_pkg::*;
(
	// Clock and reset
	input  wire logic     ref_clk,
	input  wire logic     nrst,
	// Register port
	input  wire uff_sfr_s sfr,
	output logic [7:0]    sfr_rdata,
	// Serial pins
	input  wire logic     serial_in_pin,
	output logic          serial_out_pin,
	// Interrupt requests
	output logic          tx_irq,
	output logic          rx_irq
);

	// Registered state and its next value
	uff_state_s s;
	uff_state_s n;

	// Baud timer overflow strobes
	logic       tovf;
	logic       rovf;

	// Frame shape decoded from the mode register
	logic [2:0] last_idx;
	logic       two_stop;
	logic       opt_bit;
	logic       xb_mode;
	logic [7:0] len_mask;
	// Parity of outgoing and incoming data
	logic       tx_par;
	logic       rx_par;
	// Receive acceptance terms
	logic       stop_ok;
	logic       filt_ok;

	// Parity bit for the selected type over masked data
	function automatic logic calc_par(input logic [7:0] d, input logic [1:0] t);
		case (t)
			PAR_ODD:  calc_par = ~^d;
			PAR_EVEN: calc_par = ^d;
			PAR_MARK: calc_par = 1'b1;
			default:  calc_par = 1'b0;
		endcase
	endfunction

	// Data bits beyond the selected length are masked off
	always_comb begin
		case (s.mode.data_length_select)
			DL_5:    len_mask = MASK_5;
			DL_6:    len_mask = MASK_6;
			DL_7:    len_mask = MASK_7;
			default: len_mask = MASK_8;
		endcase
	end

	assign last_idx = LAST_IDX_5 + {1'b0, s.mode.data_length_select};
	assign two_stop = s.mode.stop2 && (s.mode.data_length_select != DL_5);
	assign opt_bit  = s.mode.parity_enable | s.mode.extra_bit_enable;
	assign xb_mode  = s.mode.extra_bit_enable & ~s.mode.parity_enable;
	assign tovf     = (s.btmr == TMR_TOP);
	assign rovf     = (s.rtmr == TMR_TOP);
	assign tx_par   = calc_par(s.hold & len_mask, s.mode.parity_type_select);
	assign rx_par   = calc_par(s.rx_sh & len_mask, s.mode.parity_type_select);
	assign stop_ok  = s.rx_ok & s.rx_line;
	assign filt_ok  = ~s.mode.multiproc_filter_enable | (xb_mode & s.rx_xb);

	always_comb begin
		n = s;

		// Register writes first, so hardware sets below win
		if (sfr.wr) begin
			case (sfr.addr)
				ADDR_CTRL: begin
					n.overrun_flag       = sfr.wdata[CTL_OVR];
					n.parity_error_flag  = sfr.wdata[CTL_PERR];
					n.receive_enable_bit = sfr.wdata[CTL_REN];
					n.tx_extra_bit       = sfr.wdata[CTL_TBX];
					n.tx_done_flag       = sfr.wdata[CTL_TI];
					n.rx_ready_flag      = sfr.wdata[CTL_RI] | (s.fcnt > 2'h1);
				end
				ADDR_DATA: begin
					if (!s.hold_full) begin
						n.hold      = sfr.wdata;
						n.hold_full = 1'b1;
					end
				end
				ADDR_MODE:   n.mode = uff_mode_s'(sfr.wdata);
				ADDR_RLD_LO: n.rld[7:0] = sfr.wdata;
				ADDR_RLD_HI: n.rld[15:8] = sfr.wdata;
				default: ;
			endcase
		end

		// Register reads; data read pops the oldest entry
		if (sfr.rd) begin
			case (sfr.addr)
				ADDR_CTRL: n.rdata = {s.overrun_flag, s.parity_error_flag, ~s.hold_full,
					s.receive_enable_bit, s.tx_extra_bit, s.fifo[0].xbit,
					s.tx_done_flag, s.rx_ready_flag};
				ADDR_DATA: begin
					n.rdata = s.fifo[0].data;
					if (s.fcnt != 2'h0) begin
						n.fifo[0] = s.fifo[1];
						n.fifo[1] = s.fifo[2];
						n.fcnt    = s.fcnt - 2'h1;
					end
				end
				ADDR_MODE:   n.rdata = s.mode;
				ADDR_RLD_LO: n.rdata = s.rld[7:0];
				ADDR_RLD_HI: n.rdata = s.rld[15:8];
				default:     n.rdata = 8'h00;
			endcase
		end

		// Baud timers: one for transmit, one for receive, each restarted at frame start
		n.btmr = tovf ? s.rld : s.btmr + 16'h0001;
		n.rtmr = rovf ? s.rld : s.rtmr + 16'h0001;

		// Input synchroniser; level accepted when the last two stages agree
		n.sync = {s.sync[1:0], serial_in_pin};
		if (s.sync[1] == s.sync[2]) begin
			n.rx_line = s.sync[2];
		end

		// Transmitter, one bit per two timer overflows
		case (s.tx_st)
			ST_IDLE: begin
				n.tx_line = 1'b1;
				if (s.hold_full && !sfr.wr) begin
					n.tx_sh     = s.hold;
					n.tx_xb     = s.mode.parity_enable ? tx_par : s.tx_extra_bit;
					n.hold_full = 1'b0;
					n.tx_st     = ST_START;
					n.tx_line   = 1'b0;
					n.tx_half   = 1'b0;
					// Timer restarts so the start bit is whole
					n.btmr      = s.rld;
				end
			end
			ST_START, ST_DATA, ST_XBIT, ST_STOP: begin
				if (tovf) begin
					n.tx_half = ~s.tx_half;
					if (s.tx_half) begin
						case (s.tx_st)
							ST_START: begin
								n.tx_st   = ST_DATA;
								n.tx_cnt  = 3'h0;
								n.tx_line = s.tx_sh[0];
							end
							ST_DATA: begin
								n.tx_sh = s.tx_sh >> 1;
								if (s.tx_cnt == last_idx) begin
									n.tx_cnt = 3'h0;
									if (opt_bit) begin
										n.tx_st   = ST_XBIT;
										n.tx_line = s.tx_xb;
									end else begin
										n.tx_st        = ST_STOP;
										n.tx_line      = 1'b1;
										n.tx_done_flag = 1'b1;
									end
								end else begin
									n.tx_cnt  = s.tx_cnt + 3'h1;
									n.tx_line = s.tx_sh[1];
								end
							end
							ST_XBIT: begin
								n.tx_st        = ST_STOP;
								n.tx_line      = 1'b1;
								n.tx_done_flag = 1'b1;
							end
							default: begin
								// Second stop bit only for 6 to 8 data bits
								if (two_stop && s.tx_cnt == 3'h0) begin
									n.tx_cnt = 3'h1;
								end else begin
									n.tx_st = ST_IDLE;
								end
							end
						endcase
					end
				end
			end
			default: n.tx_st = ST_IDLE;
		endcase

		// Receiver, sampling at bit centres
		case (s.rx_st)
			ST_IDLE: begin
				if (s.receive_enable_bit && !s.rx_line) begin
					n.rx_st   = ST_START;
					n.rtmr    = s.rld;
					n.rx_half = 1'b0;
					n.rx_sh   = 8'h00;
				end
			end
			ST_START: begin
				if (rovf) begin
					n.rx_st   = s.rx_line ? ST_IDLE : ST_DATA;
					n.rx_cnt  = 3'h0;
					n.rx_half = 1'b0;
				end
			end
			ST_DATA, ST_XBIT, ST_STOP: begin
				if (rovf) begin
					n.rx_half = ~s.rx_half;
					if (s.rx_half) begin
						case (s.rx_st)
							ST_DATA: begin
								n.rx_sh[s.rx_cnt] = s.rx_line;
								if (s.rx_cnt == last_idx) begin
									n.rx_cnt = 3'h0;
									n.rx_ok  = 1'b1;
									n.rx_st  = opt_bit ? ST_XBIT : ST_STOP;
								end else begin
									n.rx_cnt = s.rx_cnt + 3'h1;
								end
							end
							ST_XBIT: begin
								n.rx_xb = s.rx_line;
								n.rx_st = ST_STOP;
							end
							default: begin
								n.rx_ok = stop_ok;
								if (two_stop && s.rx_cnt == 3'h0) begin
									n.rx_cnt = 3'h1;
								end else begin
									n.rx_st = ST_IDLE;
									if (s.mode.parity_enable && s.rx_xb != rx_par) begin
										n.parity_error_flag = 1'b1;
									end
									// Store, or flag overrun when all entries are taken
									if (stop_ok && filt_ok) begin
										if (n.fcnt == FIFO_DEPTH) begin
											n.overrun_flag = 1'b1;
										end else begin
											n.fifo[n.fcnt].data = s.rx_sh;
											n.fifo[n.fcnt].xbit = xb_mode ? s.rx_xb : 1'b1;
											n.fcnt = n.fcnt + 2'h1;
											n.rx_ready_flag = 1'b1;
										end
									end
								end
							end
						endcase
					end
				end
			end
			default: n.rx_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s                    <= '0;
			s.mode               <= uff_mode_s'(MODE_RST);
			s.rld                <= RLD_RST;
			s.btmr               <= RLD_RST;
			s.rtmr               <= RLD_RST;
			s.sync               <= SYNC_RST;
			// Lines idle high out of reset
			s.rx_line            <= 1'b1;
			s.tx_line            <= 1'b1;
			s.tx_st              <= ST_IDLE;
			s.rx_st              <= ST_IDLE;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from flip-flops
	assign sfr_rdata      = s.rdata;
	assign serial_out_pin = s.tx_line;
	assign tx_irq         = s.tx_done_flag;
	assign rx_irq         = s.rx_ready_flag;

endmodule
`default_nettype wire

// File: testbench/uff_uart_properties.sv
`timescale 1ns/1ps
`default_nettype none
module uff_uart_properties
	import uff_pkg::*;
(
	// Clock, reset, registers
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire uff_sfr_s   sfr,
	input wire logic [7:0] sfr_rdata,
	// Pins and requests
	input wire logic       serial_in_pin,
	input wire logic       serial_out_pin,
	input wire logic       tx_irq,
	input wire logic       rx_irq
);
	logic rd_ctl_r;
	logic ovr_seen_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Overrun already shown to software
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rd_ctl_r <= 1'b0;
			ovr_seen_r <= 1'b0;
		end else begin
			rd_ctl_r <= sfr.rd && sfr.addr == ADDR_CTRL;
			if (rd_ctl_r && sfr_rdata[CTL_OVR])
				ovr_seen_r <= 1'b1;
			else if (sfr.wr && sfr.addr == ADDR_CTRL && !sfr.wdata[CTL_OVR])
				ovr_seen_r <= 1'b0;
		end
	end
	property p_rdata_hold;
		!$past(sfr.rd) |-> $stable(sfr_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
	property p_tx_clear;
		$fell(tx_irq) |-> $past(sfr.wr && sfr.addr == ADDR_CTRL && !sfr.wdata[CTL_TI]);
	endproperty
	a_tx_clear: assert property (p_tx_clear) else $error("tx done fell alone");
	property p_rx_clear;
		$fell(rx_irq) |-> $past(sfr.wr && sfr.addr == ADDR_CTRL && !sfr.wdata[CTL_RI]);
	endproperty
	a_rx_clear: assert property (p_rx_clear) else $error("rx ready fell alone");
	property p_stop_high;
		$rose(tx_irq) |-> serial_out_pin [*8];
	endproperty
	a_stop_high: assert property (p_stop_high) else $error("stop not high");
	property p_start_low;
		$fell(serial_out_pin) |-> !serial_out_pin [*4];
	endproperty
	a_start_low: assert property (p_start_low) else $error("start too short");
	property p_ctl_flags;
		sfr.rd && sfr.addr == ADDR_CTRL |=>
			sfr_rdata[CTL_TI] == $past(tx_irq) && sfr_rdata[CTL_RI] == $past(rx_irq);
	endproperty
	a_ctl_flags: assert property (p_ctl_flags) else $error("flag read wrong");
	property p_rx_stop;
		$rose(rx_irq) && !$past(sfr.wr) |-> $past(serial_in_pin, 5);
	endproperty
	a_rx_stop: assert property (p_rx_stop) else $error("stored on low stop");
	property p_ovr_sticky;
		rd_ctl_r && ovr_seen_r |-> sfr_rdata[CTL_OVR];
	endproperty
	a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun lost");
endmodule
bind uff_uart uff_uart_properties chk_u (.ref_clk(ref_clk), .nrst(nrst), .sfr(sfr), .sfr_rdata(sfr_rdata),
	.serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire

// File: testbench/uff_node.sv
`timescale 1ns/1ps
`default_nettype none
module uff_node #(
	parameter int BIT_NS = 1600
) (
	// Serial lines
	output logic     line_out,
	input wire logic line_in
);
	logic [9:0] cap;
	int         nfr;
	initial begin
		line_out = 1'b1;
		nfr = 0;
		cap = '0;
	end
	task automatic send(input logic [7:0] d, input int n, input logic oe, input logic ob, input logic stop);
		line_out = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < n; i++) begin
			line_out = d[i];
			#(BIT_NS);
		end
		if (oe) begin
			line_out = ob;
			#(BIT_NS);
		end
		line_out = stop;
		#(BIT_NS);
		line_out = 1'b1;
		#(BIT_NS);
	endtask
	// Quarter bit late sampling tolerates a shortened start bit
	always begin
		@(negedge line_in);
		#(BIT_NS / 4);
		for (int j = 0; j < 10; j++) begin
			#(BIT_NS);
			cap[j] = line_in;
		end
		nfr = nfr + 1;
	end
endmodule
`default_nettype wire

// File: testbench/uff_uart_test.sv
`timescale 1ns/1ps
`default_nettype none
module uff_uart_test
	import uff_pkg::*;
;
	logic       ref_clk;
	logic       nrst;
	uff_sfr_s   sfr;
	logic [7:0] sfr_rdata;
	logic       serial_in_pin;
	logic       serial_out_pin;
	logic       tx_irq;
	logic       rx_irq;
	int         num_errors;
	int         num_checks;
	uff_uart dut_u (.ref_clk(ref_clk), .nrst(nrst), .sfr(sfr), .sfr_rdata(sfr_rdata), .serial_in_pin(serial_in_pin),
		.serial_out_pin(serial_out_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));
	uff_node node_u (.line_out(serial_in_pin), .line_in(serial_out_pin));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge ref_clk);
		sfr.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(negedge ref_clk);
		sfr.rd = 1'b0;
		d = sfr_rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
		logic [7:0] v;
		rd(a, v);
		chk(nm, {2'h0, e}, {2'h0, v & m});
	endtask
	task automatic end_sim();
		if (num_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_regs();
		rc(ADDR_CTRL, 8'hFF, 8'h20, "ctrl");
		rc(ADDR_MODE, 8'hFF, MODE_RST, "mode");
		rc(8'h00, 8'hFF, 8'h00, "unmapped");
		wr(ADDR_RLD_LO, 8'hF8);
		wr(ADDR_RLD_HI, 8'hFF);
		rc(ADDR_RLD_LO, 8'hFF, 8'hF8, "reload");
		rc(ADDR_RLD_HI, 8'hFF, 8'hFF, "reload hi");
	endtask
	task automatic t_tx();
		logic [33:0] tv [10] = '{{8'h0C, 8'h00, 8'hA4, 10'h3A4}, {8'h1C, 8'h00, 8'hA4, 10'h2A4},
			{8'h3C, 8'h00, 8'hA4, 10'h3A4}, {8'h5C, 8'h00, 8'hA4, 10'h3A4}, {8'h7C, 8'h00, 8'hA4, 10'h2A4},
			{8'h0E, 8'h00, 8'hA4, 10'h2A4}, {8'h0E, 8'h08, 8'hA4, 10'h3A4}, {8'h00, 8'h00, 8'h00, 10'h3E0},
			{8'h04, 8'h00, 8'h00, 10'h3C0}, {8'h08, 8'h00, 8'h00, 10'h380}};
		int n0;
		for (int k = 0; k < 10; k++) begin
			wr(ADDR_MODE, tv[k][33:26]);
			wr(ADDR_CTRL, tv[k][25:18]);
			n0 = node_u.nfr;
			wr(ADDR_DATA, tv[k][17:10]);
			for (int i = 0; i < 400 && tx_irq !== 1'b1; i++) @(negedge ref_clk);
			chk("tx_irq", 10'h001, {9'h0, tx_irq});
			for (int i = 0; i < 100 && node_u.nfr == n0; i++) @(negedge ref_clk);
			chk("tx frame", tv[k][9:0], node_u.cap);
		end
	endtask
	task automatic t_rx();
		logic [7:0] v;
		wr(ADDR_MODE, 8'h0C);
		wr(ADDR_CTRL, 8'h00);
		node_u.send(8'h5A, 8, 1'b0, 1'b0, 1'b1);
		rc(ADDR_CTRL, 8'hFB, 8'h20, "rx off");
		wr(ADDR_CTRL, 8'h10);
		node_u.send(8'h3C, 8, 1'b0, 1'b0, 1'b0);
		rc(ADDR_CTRL, 8'hFB, 8'h30, "bad stop");
		for (int k = 0; k < 4; k++) node_u.send(8'(8'h11 * (k + 1)), 8, 1'b0, 1'b0, 1'b1);
		rc(ADDR_CTRL, 8'hFF, 8'hB5, "full");
		chk("rx_irq", 10'h001, {9'h0, rx_irq});
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_CTRL, 8'h90);
			rc(ADDR_DATA, 8'hFF, 8'(8'h11 * (k + 1)), "fifo data");
			rd(ADDR_CTRL, v);
			chk("ri", {9'h0, k < 2}, {9'h0, v[CTL_RI]});
			chk("ovr", 10'h001, {9'h0, v[CTL_OVR]});
		end
		wr(ADDR_CTRL, 8'h10);
		rc(ADDR_CTRL, 8'hFB, 8'h30, "ovr clear");
	endtask
	task automatic t_par_mce();
		wr(ADDR_MODE, 8'h1C);
		node_u.send(8'hA4, 8, 1'b1, 1'b1, 1'b1);
		rc(ADDR_CTRL, 8'hFB, 8'h71, "parity err");
		wr(ADDR_CTRL, 8'h10);
		rc(ADDR_DATA, 8'hFF, 8'hA4, "par data");
		rc(ADDR_CTRL, 8'hFB, 8'h30, "perr clear");
		wr(ADDR_MODE, 8'h8E);
		node_u.send(8'h77, 8, 1'b1, 1'b0, 1'b1);
		rc(ADDR_CTRL, 8'hFB, 8'h30, "data frame");
		node_u.send(8'h78, 8, 1'b1, 1'b1, 1'b1);
		rc(ADDR_CTRL, 8'hFF, 8'h35, "addr frame");
		rc(ADDR_DATA, 8'hFF, 8'h78, "addr data");
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		end_sim();
	end
	initial begin
		num_errors = 0;
		num_checks = 0;
		nrst = 1'b0;
		sfr = '0;
		repeat (12) @(negedge ref_clk);
		nrst = 1'b1;
		t_regs();
		t_tx();
		t_rx();
		t_par_mce();
		end_sim();
	end
endmodule
`default_nettype wire
